// ===== common/cpm_pkg.sv
package cpm_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int ID_W = 29;
    localparam int BYTE_CNT = 8;

    // Register byte addresses
    localparam logic [11:0] OFS_EXP_ID = 12'hB0C;
    localparam logic [11:0] OFS_EDL_0_3 = 12'hB14;
    localparam logic [11:0] OFS_EDL_4_7 = 12'hB18;
    localparam logic [11:0] OFS_ID_MASK_HIGH = 12'hB1C;
    localparam logic [11:0] OFS_DATA_MASK_HIGH_0_3 = 12'hB20;
    localparam logic [11:0] OFS_MATCH_CTRL = 12'hB30;
    localparam logic [11:0] OFS_MATCH_STATUS = 12'hB34;

    // Reset values
    localparam logic [31:0] RST_EXP_ID = 32'h00000000;
    localparam logic [31:0] RST_EDL = 32'h00000000;
    localparam logic [31:0] RST_ID_MASK_HIGH = 32'h00000000;
    localparam logic [31:0] RST_DATA_MASK_HIGH = 32'h00000000;
    localparam logic [3:0] RST_MATCH_CTRL = 4'h0;

    // Field positions
    localparam int POS_FORMAT_BIT = 30;
    localparam int POS_REMOTE_BIT = 29;
    localparam int POS_ID_FILTER_SEL = 0;
    localparam int POS_DATA_FILTER_SEL = 2;
    localparam int POS_ST_ID_MATCH = 0;
    localparam int POS_ST_DATA_MATCH = 1;
    localparam int POS_ST_FRAME_MATCH = 2;
    localparam int POS_ST_WR_BLOCKED = 3;
    localparam int STD_ID_LSB = 18;

    // Writable bits of the identifier registers (bit 31 reserved)
    localparam logic [31:0] ID_REG_WMASK = 32'h7FFFFFFF;
    localparam logic [28:0] STD_ID_KEEP = 29'h1FFC0000;

    typedef enum logic [1:0] {
        CPM_FT_MASK = 2'b00,
        CPM_FT_EXACT_A = 2'b01,
        CPM_FT_EXACT_B = 2'b10,
        CPM_FT_RANGE = 2'b11
    } cpm_ft_t;

    typedef struct packed {
        logic [ID_W-1:0] id;
        logic ide;
        logic rtr;
        logic [63:0] data;
    } cpm_frame_t;

    typedef struct packed {
        logic id_match;
        logic data_match;
        logic frame_match;
    } cpm_result_t;

endpackage

// ===== verilog/cpm_field_cmp.sv
`timescale 1ns/100ps
module cpm_field_cmp #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] rx_value, // Received field
    input wire logic [WIDTH-1:0] low_value, // Expected value or lower bound
    input wire logic [WIDTH-1:0] high_value, // Mask or upper bound
    input wire cpm_pkg::cpm_ft_t filter_type, // Filter type select
    output logic hit // Field matches
);

    always_comb begin
        unique case (filter_type)
            cpm_pkg::CPM_FT_MASK: begin
                hit = ((rx_value ^ low_value) & high_value) == '0;
            end
            cpm_pkg::CPM_FT_EXACT_A, cpm_pkg::CPM_FT_EXACT_B: begin
                hit = rx_value == low_value;
            end
            cpm_pkg::CPM_FT_RANGE: begin
                hit = (rx_value >= low_value) && (rx_value <= high_value);
            end
        endcase
    end

endmodule

// ===== verilog/cpm_match_cfg.sv
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
module cpm_match_cfg (
    input wire logic clock, // System clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire logic [11:0] reg_addr, // Register byte address
    input wire logic [31:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [31:0] reg_rdata, // Read data, cycle after strobe
    input wire logic inactive_mode, // Controller is in inactive mode
    input wire logic [31:0] data_high_4_7, // Mask or upper bound, bytes 4-7
    input wire logic frame_valid, // Candidate frame present
    input wire cpm_pkg::cpm_frame_t frame, // Candidate frame fields
    output logic match_valid, // Result pulse
    output cpm_pkg::cpm_result_t match_result // Result of last frame
);

    logic [31:0] exp_id_r;
    logic [31:0] edl_0_3_r;
    logic [31:0] edl_4_7_r;
    logic [31:0] id_mask_high_r;
    logic [31:0] data_mask_high_r;
    logic [3:0] match_ctrl_r;
    logic wr_blocked_r;
    logic [31:0] reg_rdata_r;
    logic match_valid_r;
    cpm_pkg::cpm_result_t match_result_r;

    logic cfg_hit;
    logic cfg_wr_ok;
    cpm_pkg::cpm_ft_t id_ft;
    cpm_pkg::cpm_ft_t data_ft;
    logic [28:0] id_keep;
    logic [28:0] rx_id_cmp;
    logic [28:0] exp_id_cmp;
    logic [28:0] id_high_cmp;
    logic id_field_hit;
    logic format_hit;
    logic remote_hit;
    logic id_hit;
    logic [63:0] low_bytes;
    logic [63:0] high_bytes;
    logic [cpm_pkg::BYTE_CNT-1:0] byte_hit;
    logic data_hit;

    // Register decode
    always_comb begin
        cfg_hit = (reg_addr == cpm_pkg::OFS_EXP_ID) || (reg_addr == cpm_pkg::OFS_EDL_0_3)
            || (reg_addr == cpm_pkg::OFS_EDL_4_7) || (reg_addr == cpm_pkg::OFS_ID_MASK_HIGH)
            || (reg_addr == cpm_pkg::OFS_DATA_MASK_HIGH_0_3) || (reg_addr == cpm_pkg::OFS_MATCH_CTRL);
    end

    assign cfg_wr_ok = reg_wr && cfg_hit && inactive_mode;

    // Matching configuration; held while the controller is active
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            exp_id_r <= cpm_pkg::RST_EXP_ID;
            edl_0_3_r <= cpm_pkg::RST_EDL;
            edl_4_7_r <= cpm_pkg::RST_EDL;
            id_mask_high_r <= cpm_pkg::RST_ID_MASK_HIGH;
            data_mask_high_r <= cpm_pkg::RST_DATA_MASK_HIGH;
            match_ctrl_r <= cpm_pkg::RST_MATCH_CTRL;
        end else if (cfg_wr_ok) begin
            unique case (reg_addr)
                cpm_pkg::OFS_EXP_ID: begin
                    exp_id_r <= reg_wdata & cpm_pkg::ID_REG_WMASK;
                end
                cpm_pkg::OFS_EDL_0_3: begin
                    edl_0_3_r <= reg_wdata;
                end
                cpm_pkg::OFS_EDL_4_7: begin
                    edl_4_7_r <= reg_wdata;
                end
                cpm_pkg::OFS_ID_MASK_HIGH: begin
                    id_mask_high_r <= reg_wdata & cpm_pkg::ID_REG_WMASK;
                end
                cpm_pkg::OFS_DATA_MASK_HIGH_0_3: begin
                    data_mask_high_r <= reg_wdata;
                end
                default: begin
                    match_ctrl_r <= reg_wdata[3:0];
                end
            endcase
        end
    end

    // Sticky flag for a refused write; a new refusal wins over the clear
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_blocked_r <= 1'b0;
        end else if (reg_wr && cfg_hit && !inactive_mode) begin
            wr_blocked_r <= 1'b1;
        end else if (reg_wr && reg_addr == cpm_pkg::OFS_MATCH_STATUS
                && reg_wdata[cpm_pkg::POS_ST_WR_BLOCKED]) begin
            wr_blocked_r <= 1'b0;
        end
    end

    // Read port; unmapped addresses read zero
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata_r <= 32'h00000000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                cpm_pkg::OFS_EXP_ID: reg_rdata_r <= exp_id_r;
                cpm_pkg::OFS_EDL_0_3: reg_rdata_r <= edl_0_3_r;
                cpm_pkg::OFS_EDL_4_7: reg_rdata_r <= edl_4_7_r;
                cpm_pkg::OFS_ID_MASK_HIGH: reg_rdata_r <= id_mask_high_r;
                cpm_pkg::OFS_DATA_MASK_HIGH_0_3: reg_rdata_r <= data_mask_high_r;
                cpm_pkg::OFS_MATCH_CTRL: reg_rdata_r <= {28'h0000000, match_ctrl_r};
                cpm_pkg::OFS_MATCH_STATUS: begin
                    reg_rdata_r <= {28'h0000000, wr_blocked_r, match_result_r.frame_match,
                        match_result_r.data_match, match_result_r.id_match};
                end
                default: reg_rdata_r <= 32'h00000000;
            endcase
        end else begin
            reg_rdata_r <= 32'h00000000;
        end
    end

    assign reg_rdata = reg_rdata_r;

    assign id_ft = cpm_pkg::cpm_ft_t'(match_ctrl_r[cpm_pkg::POS_ID_FILTER_SEL +: 2]);
    assign data_ft = cpm_pkg::cpm_ft_t'(match_ctrl_r[cpm_pkg::POS_DATA_FILTER_SEL +: 2]);

    // Standard frames drop the low identifier bits from every operand
    assign id_keep = frame.ide ? {cpm_pkg::ID_W{1'b1}} : cpm_pkg::STD_ID_KEEP;
    assign rx_id_cmp = frame.id & id_keep;
    assign exp_id_cmp = exp_id_r[28:0] & id_keep;
    assign id_high_cmp = id_mask_high_r[28:0] & id_keep;

    cpm_field_cmp #(
        .WIDTH(cpm_pkg::ID_W)
    ) u_id_cmp (
        .rx_value(rx_id_cmp),
        .low_value(exp_id_cmp),
        .high_value(id_high_cmp),
        .filter_type(id_ft),
        .hit(id_field_hit)
    );

    assign format_hit = !id_mask_high_r[cpm_pkg::POS_FORMAT_BIT]
        || (frame.ide == exp_id_r[cpm_pkg::POS_FORMAT_BIT]);
    assign remote_hit = !id_mask_high_r[cpm_pkg::POS_REMOTE_BIT]
        || (frame.rtr == exp_id_r[cpm_pkg::POS_REMOTE_BIT]);
    assign id_hit = id_field_hit && format_hit && remote_hit;

    // Bytes 0 and 4 sit in the top lane of their words
    assign low_bytes = {edl_0_3_r, edl_4_7_r};
    assign high_bytes = {data_mask_high_r, data_high_4_7};

    genvar gi;
    generate
        for (gi = 0; gi < cpm_pkg::BYTE_CNT; gi++) begin : g_byte
            cpm_field_cmp #(
                .WIDTH(8)
            ) u_byte_cmp (
                .rx_value(frame.data[63 - 8 * gi -: 8]),
                .low_value(low_bytes[63 - 8 * gi -: 8]),
                .high_value(high_bytes[63 - 8 * gi -: 8]),
                .filter_type(data_ft),
                .hit(byte_hit[gi])
            );
        end
    endgenerate

    assign data_hit = &byte_hit;

    // Result registered on each candidate frame
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            match_valid_r <= 1'b0;
        end else begin
            match_valid_r <= frame_valid;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            match_result_r <= '0;
        end else if (frame_valid) begin
            match_result_r.id_match <= id_hit;
            match_result_r.data_match <= data_hit;
            match_result_r.frame_match <= id_hit && data_hit;
        end
    end

    assign match_valid = match_valid_r;
    assign match_result = match_result_r;

endmodule

// ===== tb/cpm_props.sv
`timescale 1ns/100ps
module cpm_props (
    input wire logic clock, // Clock
    input wire logic sys_rst, // Reset
    input wire logic [11:0] reg_addr, // Address
    input wire logic [31:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write
    input wire logic reg_rd, // Read
    input wire logic [31:0] reg_rdata, // Read data
    input wire logic inactive_mode, // Inactive
    input wire logic [31:0] data_high_4_7, // Bytes 4-7 bound
    input wire logic frame_valid, // Frame in
    input wire cpm_pkg::cpm_frame_t frame, // Frame
    input wire logic match_valid, // Result pulse
    input wire cpm_pkg::cpm_result_t match_result // Result
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    property p_wrrd(a, m);
        (reg_wr && inactive_mode && reg_addr == a) ##1 (reg_rd && reg_addr == a)
            |=> reg_rdata == ($past(reg_wdata, 2) & m);
    endproperty
    a_exp_id_rb: assert property (p_wrrd(12'hB0C, 32'h7FFFFFFF)) else $error("id readback");
    a_low03_rb: assert property (p_wrrd(12'hB14, 32'hFFFFFFFF)) else $error("low0 readback");
    a_low47_rb: assert property (p_wrrd(12'hB18, 32'hFFFFFFFF)) else $error("low1 readback");
    a_id_filt_rb: assert property (p_wrrd(12'hB1C, 32'h7FFFFFFF)) else $error("idf readback");
    a_data_filt_rb: assert property (p_wrrd(12'hB20, 32'hFFFFFFFF)) else $error("df readback");
    a_ctrl_rb: assert property (p_wrrd(12'hB30, 32'h0000000F)) else $error("ctrl readback");
    a_wr_refused: assert property ((reg_wr && !inactive_mode && reg_addr == 12'hB0C)
        ##1 (reg_rd && reg_addr == 12'hB34) |=> reg_rdata[3]) else $error("refusal flag");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("rdata idle");
    a_match_lat: assert property (frame_valid |=> match_valid) else $error("match late");
    a_match_pulse: assert property (!frame_valid |=> !match_valid) else $error("match extra");
    a_result_hold: assert property (!frame_valid |=> $stable(match_result)) else $error("result moved");
    c_frame_hit: cover property (match_valid && match_result.frame_match);
    c_refused: cover property (reg_wr && !inactive_mode);
    c_read: cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule
bind cpm_match_cfg cpm_props cpm_props_inst (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .inactive_mode, .data_high_4_7, .frame_valid, .frame, .match_valid, .match_result);

// ===== tb/cpm_node_model.sv
`timescale 1ns/100ps
module cpm_node_model (
    input wire logic clock, // Clock
    input wire logic sys_rst, // Reset
    input wire logic go, // Send request
    input wire cpm_pkg::cpm_frame_t fin, // Frame to send
    output logic frame_valid, // Frame present
    output cpm_pkg::cpm_frame_t frame // Frame fields
);
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            frame_valid <= 1'b0;
            frame <= '0;
        end else begin
            frame_valid <= go;
            // Churn between frames so stale fields never match by luck
            frame <= go ? fin : ~frame;
        end
    end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic inactive_mode = 1'b1;
    logic [31:0] data_high_4_7 = 32'h0;
    logic go = 1'b0;
    cpm_pkg::cpm_frame_t fin = '0;
    logic [31:0] reg_rdata;
    logic frame_valid;
    logic match_valid;
    cpm_pkg::cpm_frame_t frame;
    cpm_pkg::cpm_result_t match_result;
    cpm_pkg::cpm_result_t r_last = '0;
    logic [31:0] seed = 32'h6579;
    logic [31:0] m[6] = '{default: 32'h0};
    logic blk = 1'b0;
    int errors = 0;
    int tests_run = 0;
    localparam logic [11:0] ADR[6] = '{12'hB0C, 12'hB14, 12'hB18, 12'hB1C, 12'hB20, 12'hB30};
    localparam logic [31:0] MSK[6] = '{32'h7FFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h7FFFFFFF, 32'hFFFFFFFF, 32'hF};
    initial forever #25 clock = ~clock;
    cpm_match_cfg cpm_match_cfg_inst (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .inactive_mode, .data_high_4_7, .frame_valid, .frame, .match_valid, .match_result);
    cpm_node_model cpm_node_model_inst (.clock, .sys_rst, .go, .fin, .frame_valid, .frame);
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic bit fm(logic [28:0] x, logic [28:0] l, logic [28:0] h, logic [1:0] s);
        case (s)
            2'h0: return ((x ^ l) & h) == 29'h0;
            2'h3: return x >= l && x <= h;
            default: return x == l;
        endcase
    endfunction
    function automatic cpm_pkg::cpm_result_t expf(cpm_pkg::cpm_frame_t f);
        logic [28:0] x, l, h;
        logic [63:0] dl, dh;
        cpm_pkg::cpm_result_t r;
        x = f.id;
        l = m[0][28:0];
        h = m[3][28:0];
        if (!f.ide) begin
            x &= 29'h1FFC0000;
            l &= 29'h1FFC0000;
            h &= 29'h1FFC0000;
        end
        r.id_match = fm(x, l, h, m[5][1:0]) && !(m[3][30] && f.ide != m[0][30])
            && !(m[3][29] && f.rtr != m[0][29]);
        dl = {m[1], m[2]};
        dh = {m[4], data_high_4_7};
        r.data_match = 1'b1;
        for (int k = 0; k < 8; k++)
            if (!fm(29'(f.data[63-8*k -: 8]), 29'(dl[63-8*k -: 8]), 29'(dh[63-8*k -: 8]), m[5][3:2]))
                r.data_match = 1'b0;
        r.frame_match = r.id_match && r.data_match;
        return r;
    endfunction
    task automatic cmp32(logic [31:0] g, logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp_res(logic v, cpm_pkg::cpm_result_t g, cpm_pkg::cpm_result_t e);
        tests_run++;
        if (v !== 1'b1 || g !== e) begin
            errors++;
            $display("MISMATCH t=%0t match got %b %b exp 1 %b", $time, v, g, e);
        end
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        for (int i = 0; i < 6; i++)
            if (a == ADR[i]) begin
                if (inactive_mode)
                    m[i] = d & MSK[i];
                else
                    blk = 1'b1;
            end
        if (a == 12'hB34 && d[3])
            blk = 1'b0;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [11:0] a, logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 cmp32(reg_rdata, e);
    endtask
    task automatic send(cpm_pkg::cpm_frame_t f);
        fin <= f;
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        @(posedge clock);
        r_last = expf(f);
        #1 cmp_res(match_valid, match_result, r_last);
    endtask
    task automatic finish_test();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        cpm_pkg::cpm_frame_t f;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 6; i++)
            rd(ADR[i], 32'h0);
        rd(12'hB10, 32'h0);
        for (int n = 0; n < 60; n++) begin
            inactive_mode <= xs() % 4 != 0;
            data_high_4_7 <= xs();
            @(posedge clock);
            for (int i = 0; i < 6; i++) begin
                wr(ADR[i], xs());
                rd(ADR[i], m[i]);
            end
            wr(12'hB0C, xs());
            rd(12'hB34, {28'h0, blk, r_last.frame_match, r_last.data_match, r_last.id_match});
            case (xs() % 3)
                0: f.data = {m[1], m[2]};
                1: f.data = {m[4], data_high_4_7};
                default: f.data = {xs(), xs()};
            endcase
            f.id = (xs() % 2 == 0) ? m[0][28:0] : m[3][28:0];
            f.id ^= (xs() % 4 == 0) ? 29'(xs()) : 29'h0;
            f.ide = m[0][30] ^ (xs() % 4 == 0);
            f.rtr = m[0][29] ^ (xs() % 4 == 0);
            send(f);
            wr(12'hB34, xs());
        end
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        finish_test();
    end
endmodule
